// >>> top_level_walk_cache_pkg.sv
/*
  Constants and types for the level-5 walk cache: entry bit layout,
  register map, control fields and state encodings.
  Assumes 64-bit paging-structure entries and a 32-bit AXI4-Lite bus.
*/
package top_level_walk_cache_pkg;
  localparam int ADDR_W = 64;
  localparam int PA_LO = 12;
  localparam int PA_W = 40;
  localparam int SID_W = 16;
  localparam int PASID_W = 20;
  localparam int DID_W = 16;
  localparam int TAG_W = 16;
  localparam int TAG_LO = 48;
  localparam int FL_TAG_W = 9;
  // First-level entry flags
  localparam int BIT_P = 0;
  localparam int BIT_RW = 1;
  localparam int BIT_US = 2;
  localparam int BIT_PWT = 3;
  localparam int BIT_PCD = 4;
  localparam int BIT_A = 5;
  localparam int BIT_LEAF_SIZE = 7;
  localparam int BIT_G = 8;
  localparam int BIT_EA = 10;
  localparam int BIT_XD = 63;
  // Second-level entry flags
  localparam int BIT_R = 0;
  localparam int BIT_W = 1;
  localparam int BIT_X = 2;
  localparam logic [63:0] FL_RSVD_MASK = 64'h7FF0_0000_0000_0080;
  localparam logic [63:0] SL_RSVD_MASK = 64'h7FF0_0000_0000_00F8;
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_HITS = 8'h04;
  localparam logic [7:0] REG_MISSES = 8'h08;
  localparam logic [7:0] REG_FILLS = 8'h0C;
  localparam logic [7:0] REG_FLUSH = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_EN = 0;
  localparam int CTRL_FAULT_CACHE = 1;
  localparam int CTRL_NXE = 2;
  localparam int CTRL_SECOND_LEVEL_EXEC_ENABLE = 3;
  localparam int CTRL_EXT_ACCESSED_FLAG_ENABLE = 4;
  localparam int CTRL_MAX_GUEST_ADDR_WIDTH_LO = 8;
  localparam int MAX_GUEST_ADDR_WIDTH_W = 6;
  localparam int FLUSH_BIT = 0;
  localparam logic [31:0] CTRL_MASK = 32'h0000_3F1F;
  localparam logic [31:0] CTRL_RESET = 32'h0000_3801;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MAP_FIRST = 2'h0,
    MAP_SECOND = 2'h1,
    MAP_NESTED = 2'h2
  } map_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_UPDATE = 3'h2,
    ST_INSTALL = 3'h4
  } fill_state_t;
  typedef struct packed {
    logic valid;
    map_mode_t mode;
    logic [TAG_W-1:0] tag;
    logic [SID_W-1:0] sid;
    logic has_pasid;
    logic [PASID_W-1:0] pasid;
    logic [DID_W-1:0] did;
    logic [PA_W-1:0] next_pa;
    logic wr;
    logic us;
    logic xd;
    logic page_cache_disable;
    logic page_write_through;
    logic rd;
    logic ex;
  } l5_entry_t;
endpackage : top_level_walk_cache_pkg

// >>> top_level_walk_cache.sv
/*
  Level-5 paging-structure cache with global-page tagging for the
  translation lookaside buffer, and an AXI4-Lite register slave.
  Assumes the page walker drives lookup, fill and update-ack ports on
  the same clock and performs memory accesses itself.
  // Function
  // - Leaf with bit 8 set marks global
  // - Global entry ignores PASID, needs source-id
  // - Global bit never affects walk caches
  // - Cache only table pointers, no page maps
  // - Cache presence and arrangement is optional
  // - Level-5 cache used only with 5-level paging
  // - First-level tag is address bits 56:48
  // - First-level entry keeps address, rights, cache flags
  // - Second-level tag spans guest width to 48
  // - Second-level entry keeps address, read, write, execute
  // - Nested tag equals first-level 9-bit tag
  // - Nested keeps translated address, ANDed write
  // - Nested keeps user flag, combined execute-disable
  // - Hit may replace fetching the entry
  // - First-level fill needs present, no reserved
  // - Nested fill also needs second-level read
  // - Second-level fill needs read or write
  // - Set accessed flags before first-level fill
  // - Fill allowed even if nothing below valid
  // - Entries may stay stale after memory changes
  // - Fault caching option lifts fill restrictions
  // - Entries tagged with source, PASID, domain
*/
// Chosen here: the register offsets and the AXI4-Lite slave port.
module top_level_walk_cache #(
  parameter int ENTRIES = 4,
  parameter int AXI_AW = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic five_level,
  input wire logic lk_valid,
  input wire top_level_walk_cache_pkg::map_mode_t lk_mode,
  input wire logic [top_level_walk_cache_pkg::ADDR_W-1:0] lk_addr,
  input wire logic [top_level_walk_cache_pkg::SID_W-1:0] lk_sid,
  input wire logic lk_has_pasid,
  input wire logic [top_level_walk_cache_pkg::PASID_W-1:0] lk_pasid,
  input wire logic [top_level_walk_cache_pkg::DID_W-1:0] lk_did,
  output logic lk_done,
  output logic lk_hit,
  output logic [top_level_walk_cache_pkg::PA_W-1:0] lk_next_pa,
  output logic lk_wr,
  output logic lk_us,
  output logic lk_xd,
  output logic lk_pcd,
  output logic lk_pwt,
  output logic lk_rd,
  output logic lk_ex,
  input wire logic fill_valid,
  output logic fill_ready,
  input wire top_level_walk_cache_pkg::map_mode_t fill_mode,
  input wire logic [top_level_walk_cache_pkg::ADDR_W-1:0] fill_addr,
  input wire logic [top_level_walk_cache_pkg::SID_W-1:0] fill_sid,
  input wire logic fill_has_pasid,
  input wire logic [top_level_walk_cache_pkg::PASID_W-1:0] fill_pasid,
  input wire logic [top_level_walk_cache_pkg::DID_W-1:0] fill_did,
  input wire logic [63:0] fill_entry,
  input wire logic [top_level_walk_cache_pkg::PA_W-1:0] fill_sl_pa,
  input wire logic fill_sl_rd,
  input wire logic fill_sl_wr,
  input wire logic fill_sl_ex,
  output logic fill_done,
  output logic fill_cached,
  output logic upd_valid,
  output logic [63:0] upd_entry,
  input wire logic upd_ack,
  input wire logic leaf_valid,
  input wire logic [63:0] leaf_entry,
  input wire logic leaf_is_pte,
  output logic leaf_global,
  input wire logic chk_valid,
  input wire logic chk_global,
  input wire logic [top_level_walk_cache_pkg::SID_W-1:0] chk_entry_sid,
  input wire logic [top_level_walk_cache_pkg::PASID_W-1:0] chk_entry_pasid,
  input wire logic [top_level_walk_cache_pkg::SID_W-1:0] chk_req_sid,
  input wire logic chk_req_has_pasid,
  input wire logic [top_level_walk_cache_pkg::PASID_W-1:0] chk_req_pasid,
  output logic chk_match
);
  import top_level_walk_cache_pkg::*;

  localparam int VW = $clog2(ENTRIES);

  if (ENTRIES < 2 || ENTRIES > 64 || AXI_AW < 8)
  begin : g_check
    $error("top_level_walk_cache: unsupported ENTRIES or AXI_AW");
  end

  typedef struct packed {
    l5_entry_t [ENTRIES-1:0] ent;
    logic [VW-1:0] victim;
    fill_state_t fst;
    l5_entry_t pend;
    logic [31:0] ctrl;
    logic [31:0] hits;
    logic [31:0] misses;
    logic [31:0] fills;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic lk_done;
    logic lk_hit;
    l5_entry_t lk_ent;
    logic fill_ready;
    logic fill_done;
    logic fill_cached;
    logic upd_valid;
    logic [63:0] upd_entry;
    logic leaf_global;
    logic chk_match;
  } state_t;

  state_t st;
  state_t next_st;
  logic hit_any;
  l5_entry_t hit_e;
  l5_entry_t built;
  logic elig;
  logic need_upd;
  logic [63:0] set_flags;
  logic [TAG_W-1:0] lk_tag;

  // Tag width follows the mapping type and the guest address width
  function automatic logic [TAG_W-1:0] make_tag(input logic [ADDR_W-1:0] a,
      input map_mode_t m, input logic [MAX_GUEST_ADDR_WIDTH_W-1:0] max_guest_addr_width);
    logic [TAG_W-1:0] t;
    t = a[TAG_LO +: TAG_W];
    for (int i = 0; i < TAG_W; i++)
    begin
      if (m == MAP_SECOND ? (TAG_LO + i > int'(max_guest_addr_width)) : (i >= FL_TAG_W))
        t[i] = 1'b0;
    end
    return t;
  endfunction : make_tag

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction : merge

  always_comb
  begin
    next_st = st;
    hit_any = 1'b0;
    hit_e = '0;
    built = '0;
    elig = 1'b0;
    need_upd = 1'b0;
    set_flags = '0;
    lk_tag = make_tag(lk_addr, lk_mode, st.ctrl[CTRL_MAX_GUEST_ADDR_WIDTH_LO +: MAX_GUEST_ADDR_WIDTH_W]);

    // Register slave: address and data may arrive in either order
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (st.aw_addr[7:0])
        REG_CTRL: next_st.ctrl = merge(st.ctrl, st.w_data, st.w_strb) & CTRL_MASK;
        REG_FLUSH:
        begin
          if (st.w_strb[0] && st.w_data[FLUSH_BIT])
          begin
            for (int i = 0; i < ENTRIES; i++)
              next_st.ent[i].valid = 1'b0;
          end
        end
        REG_HITS, REG_MISSES, REG_FILLS, REG_STATUS: next_st.bresp = RESP_OKAY;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;

    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (s_axi_araddr[7:0])
        REG_CTRL: next_st.rdata = st.ctrl;
        REG_HITS: next_st.rdata = st.hits;
        REG_MISSES: next_st.rdata = st.misses;
        REG_FILLS: next_st.rdata = st.fills;
        REG_FLUSH: next_st.rdata = '0;
        REG_STATUS: next_st.rdata = {29'h0, st.fst};
        default:
        begin
          next_st.rdata = '0;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;

    // Lookup; all tags must agree, PASID only when the request has one
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (st.ent[i].valid && st.ent[i].mode == lk_mode && st.ent[i].tag == lk_tag
          && st.ent[i].sid == lk_sid && st.ent[i].did == lk_did
          && st.ent[i].has_pasid == lk_has_pasid
          && (!lk_has_pasid || st.ent[i].pasid == lk_pasid))
      begin
        hit_any = 1'b1;
        hit_e = st.ent[i];
      end
    end
    next_st.lk_done = lk_valid;
    next_st.lk_hit = lk_valid && hit_any && st.ctrl[CTRL_EN] && five_level;
    // Payload is cleared on a miss and held between lookups
    if (lk_valid)
      next_st.lk_ent = next_st.lk_hit ? hit_e : '0;
    if (lk_valid)
    begin
      if (next_st.lk_hit)
        next_st.hits = st.hits + 32'h1;
      else
        next_st.misses = st.misses + 32'h1;
    end

    // Build the candidate entry; bit 8 is not looked at here
    built.valid = 1'b1;
    built.mode = fill_mode;
    built.tag = make_tag(fill_addr, fill_mode, st.ctrl[CTRL_MAX_GUEST_ADDR_WIDTH_LO +: MAX_GUEST_ADDR_WIDTH_W]);
    built.sid = fill_sid;
    built.has_pasid = fill_has_pasid;
    built.pasid = fill_has_pasid ? fill_pasid : '0;
    built.did = fill_did;
    built.next_pa = fill_entry[PA_LO +: PA_W];
    case (fill_mode)
      MAP_SECOND:
      begin
        built.rd = fill_entry[BIT_R];
        built.wr = fill_entry[BIT_W];
        built.ex = fill_entry[BIT_X];
        elig = (fill_entry[BIT_R] || fill_entry[BIT_W])
            && (fill_entry & SL_RSVD_MASK) == '0;
      end
      MAP_NESTED:
      begin
        built.next_pa = fill_sl_pa;
        built.wr = fill_entry[BIT_RW] && fill_sl_wr;
        built.us = fill_entry[BIT_US];
        built.xd = (st.ctrl[CTRL_NXE] && fill_entry[BIT_XD])
            || (st.ctrl[CTRL_SECOND_LEVEL_EXEC_ENABLE] && !fill_sl_ex);
        built.page_cache_disable = fill_entry[BIT_PCD];
        built.page_write_through = fill_entry[BIT_PWT];
        elig = fill_entry[BIT_P] && (fill_entry & FL_RSVD_MASK) == '0
            && fill_sl_rd;
      end
      default:
      begin
        built.wr = fill_entry[BIT_RW];
        built.us = fill_entry[BIT_US];
        built.xd = fill_entry[BIT_XD];
        built.page_cache_disable = fill_entry[BIT_PCD];
        built.page_write_through = fill_entry[BIT_PWT];
        elig = fill_entry[BIT_P] && (fill_entry & FL_RSVD_MASK) == '0;
      end
    endcase
    if (st.ctrl[CTRL_FAULT_CACHE])
      elig = 1'b1;
    set_flags = fill_entry;
    set_flags[BIT_A] = 1'b1;
    if (st.ctrl[CTRL_EXT_ACCESSED_FLAG_ENABLE])
      set_flags[BIT_EA] = 1'b1;
    need_upd = fill_mode != MAP_SECOND && set_flags != fill_entry;
    // Without second-level write right the flag update cannot land
    if (need_upd && fill_mode == MAP_NESTED && !fill_sl_wr)
      elig = 1'b0;

    // Fill sequence; contents of the referenced table are never checked
    next_st.fill_done = 1'b0;
    next_st.fill_cached = 1'b0;
    case (st.fst)
      ST_IDLE:
      begin
        if (fill_valid && st.fill_ready)
        begin
          next_st.pend = built;
          next_st.upd_entry = set_flags;
          if (!elig || !st.ctrl[CTRL_EN] || !five_level)
            next_st.fill_done = 1'b1;
          else if (need_upd)
          begin
            next_st.upd_valid = 1'b1;
            next_st.fst = ST_UPDATE;
          end
          else
            next_st.fst = ST_INSTALL;
        end
      end
      ST_UPDATE:
      begin
        if (upd_ack)
        begin
          next_st.upd_valid = 1'b0;
          next_st.fst = ST_INSTALL;
        end
      end
      ST_INSTALL:
      begin
        // Entry is kept as loaded until flushed or replaced
        next_st.ent[st.victim] = st.pend;
        next_st.victim = (st.victim == VW'(ENTRIES - 1)) ? '0 : st.victim + 1'b1;
        next_st.fills = st.fills + 32'h1;
        next_st.fill_done = 1'b1;
        next_st.fill_cached = 1'b1;
        next_st.fst = ST_IDLE;
      end
      default: next_st.fst = ST_IDLE;
    endcase
    next_st.fill_ready = next_st.fst == ST_IDLE;

    // Global marking for the lookaside buffer, and its PASID-blind match
    next_st.leaf_global = leaf_valid && (leaf_is_pte || leaf_entry[BIT_LEAF_SIZE])
        && leaf_entry[BIT_G];
    next_st.chk_match = chk_valid && chk_entry_sid == chk_req_sid
        && (!chk_req_has_pasid || chk_global || chk_entry_pasid == chk_req_pasid);
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.fst <= ST_IDLE;
      st.fill_ready <= 1'b1;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign lk_done = st.lk_done;
  assign lk_hit = st.lk_hit;
  assign lk_next_pa = st.lk_ent.next_pa;
  assign lk_wr = st.lk_ent.wr;
  assign lk_us = st.lk_ent.us;
  assign lk_xd = st.lk_ent.xd;
  assign lk_pcd = st.lk_ent.page_cache_disable;
  assign lk_pwt = st.lk_ent.page_write_through;
  assign lk_rd = st.lk_ent.rd;
  assign lk_ex = st.lk_ent.ex;
  assign fill_ready = st.fill_ready;
  assign fill_done = st.fill_done;
  assign fill_cached = st.fill_cached;
  assign upd_valid = st.upd_valid;
  assign upd_entry = st.upd_entry;
  assign leaf_global = st.leaf_global;
  assign chk_match = st.chk_match;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  property p_lookup_answer;
    lk_valid |=> lk_done;
  endproperty
  a_lookup_answer: assert property (p_lookup_answer) else $error("lookup not answered");

  property p_no_hit_four_level;
    lk_valid && !five_level |=> lk_done && !lk_hit;
  endproperty
  a_no_hit_four_level: assert property (p_no_hit_four_level) else $error("hit without 5-level");

  property p_disabled_misses;
    lk_valid && !st.ctrl[CTRL_EN] |=> !lk_hit ##0 st.misses == $past(st.misses) + 32'h1;
  endproperty
  a_disabled_misses: assert property (p_disabled_misses) else $error("disabled cache hit");

  property p_global_leaf;
    leaf_valid && leaf_is_pte |=> leaf_global == $past(leaf_entry[BIT_G]);
  endproperty
  a_global_leaf: assert property (p_global_leaf) else $error("global flag wrong");

  property p_first_not_present;
    fill_valid && fill_ready && fill_mode == MAP_FIRST && !fill_entry[BIT_P]
        && !st.ctrl[CTRL_FAULT_CACHE] |=> fill_done && !fill_cached && !upd_valid;
  endproperty
  a_first_not_present: assert property (p_first_not_present) else $error("bad fill");

  property p_nested_read;
    fill_valid && fill_ready && fill_mode == MAP_NESTED && !fill_sl_rd
        && !st.ctrl[CTRL_FAULT_CACHE] |=> fill_done && !fill_cached;
  endproperty
  a_nested_read: assert property (p_nested_read) else $error("nested fill no read");

  property p_second_no_rights;
    fill_valid && fill_ready && fill_mode == MAP_SECOND && !fill_entry[BIT_R]
        && !fill_entry[BIT_W] && !st.ctrl[CTRL_FAULT_CACHE] |=> fill_done && !fill_cached;
  endproperty
  a_second_no_rights: assert property (p_second_no_rights) else $error("sl fill no rights");

  property p_update_first;
    upd_valid && !upd_ack |=> upd_valid && !fill_done;
  endproperty
  a_update_first: assert property (p_update_first) else $error("fill before update");

  property p_global_match;
    chk_valid && chk_global && chk_entry_sid == chk_req_sid |=> chk_match;
  endproperty
  a_global_match: assert property (p_global_match) else $error("global entry refused");
endmodule : top_level_walk_cache

// >>> walk_memory_model.sv
/*
  Behavioural model of the walker's memory port that completes entry
  write-backs after a chosen number of cycles.
  Assumes it shares the clock and the active-low reset of the cache.
*/
module walk_memory_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic upd_valid,
  input wire logic [3:0] ack_dly,
  output logic upd_ack
);
  logic [3:0] cnt;

  // The ack is a one-cycle pulse. The request may wait several cycles,
  // so a slow memory stays visible to the cache.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      upd_ack <= 1'b0;
      cnt <= 4'h0;
    end
    else
    begin
      upd_ack <= 1'b0;
      if (upd_valid && !upd_ack)
      begin
        if (cnt >= ack_dly)
        begin
          upd_ack <= 1'b1;
          cnt <= 4'h0;
        end
        else
          cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : walk_memory_model

// >>> tb_top_level_walk_cache.sv
/*
  Self-checking bench for the level-5 walk cache: registers, fills,
  lookups, leaf tagging and lookaside tag checks.
  Assumes the package and the cache module are compiled first.
*/
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin $display("mismatch %s exp %0h got %0h", n, e, g); err_total++; end end
module tb_top_level_walk_cache import top_level_walk_cache_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] SID = 16'h0012;
  logic clock, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, ack_dly;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic five_level, lk_valid, lk_has_pasid, lk_done, lk_hit, lk_wr, lk_us, lk_xd, lk_pcd;
  logic lk_pwt, lk_rd, lk_ex, fill_valid, fill_ready, fill_has_pasid, fill_sl_rd, fill_sl_wr;
  logic fill_sl_ex, fill_done, fill_cached, upd_valid, upd_ack, leaf_valid, leaf_is_pte;
  logic leaf_global, chk_valid, chk_global, chk_req_has_pasid, chk_match, leaf_d, chk_d;
  map_mode_t lk_mode, fill_mode;
  logic [63:0] lk_addr, fill_addr, fill_entry, upd_entry, leaf_entry;
  logic [15:0] lk_sid, lk_did, fill_sid, fill_did, chk_entry_sid, chk_req_sid;
  logic [19:0] lk_pasid, fill_pasid, chk_entry_pasid, chk_req_pasid;
  logic [39:0] lk_next_pa, fill_sl_pa;
  int err_total, num_checks, cyc;
  typedef struct {logic [47:0] v; logic [47:0] m;} note_t;
  note_t q_lk[$];
  logic q_f[$], q_leaf[$], q_chk[$];
  logic [63:0] q_u[$];
  logic [33:0] q_r[$];
  logic [1:0] q_b[$];

  top_level_walk_cache u_dut (.*);
  walk_memory_model u_mem (.clock(clock), .rst_b(rst_b), .upd_valid(upd_valid),
    .ack_dly(ack_dly), .upd_ack(upd_ack));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task final_report;
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // Results are compared against notes in the order they were issued
  always @(posedge clock)
  begin
    note_t n;
    leaf_d <= leaf_valid;
    chk_d <= chk_valid;
    if (lk_done && q_lk.size() > 0)
    begin
      n = q_lk.pop_front();
      `CHK("lookup", n.v & n.m, {lk_hit, lk_next_pa, lk_wr, lk_us, lk_xd, lk_pcd, lk_pwt, lk_rd, lk_ex} & n.m)
    end
    if (fill_done) `CHK("fill_cached", q_f.pop_front(), fill_cached)
    if (upd_valid && upd_ack) `CHK("upd_entry", q_u.pop_front(), upd_entry)
    if (leaf_d) `CHK("leaf_global", q_leaf.pop_front(), leaf_global)
    if (chk_d) `CHK("chk_match", q_chk.pop_front(), chk_match)
    if (s_axi_rvalid && s_axi_rready) `CHK("rdata", q_r.pop_front(), {s_axi_rresp, s_axi_rdata})
    if (s_axi_bvalid && s_axi_bready) `CHK("bresp", q_b.pop_front(), s_axi_bresp)
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      final_report();
    end
  end

  task automatic axi_w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    q_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clock);
      if (!ad && s_axi_awready)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_w

  task automatic axi_r(input logic [7:0] a, input logic [33:0] e);
    q_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : axi_r

  task automatic look(input map_mode_t md, input logic [63:0] a, input logic [15:0] s,
    input logic [47:0] v, input logic [47:0] mk);
    q_lk.push_back('{v, mk});
    lk_mode <= md;
    lk_addr <= a;
    lk_sid <= s;
    lk_has_pasid <= fill_has_pasid;
    lk_pasid <= fill_pasid;
    lk_did <= fill_did;
    lk_valid <= 1'b1;
    @(posedge clock);
    lk_valid <= 1'b0;
    @(posedge clock);
  endtask : look

  task automatic fill(input map_mode_t md, input logic [63:0] a, input logic [63:0] e,
    input logic [2:0] sl, input logic c);
    q_f.push_back(c);
    fill_mode <= md;
    fill_addr <= a;
    fill_entry <= e;
    {fill_sl_rd, fill_sl_wr, fill_sl_ex} <= sl;
    ack_dly <= 4'($urandom_range(3));
    fill_valid <= 1'b1;
    do @(posedge clock); while (!fill_ready);
    fill_valid <= 1'b0;
    do @(posedge clock); while (!fill_done);
  endtask : fill

  initial
  begin
    logic [39:0] pa;
    void'($urandom(32'h763bda68));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
      s_axi_araddr, s_axi_wdata, lk_valid, lk_has_pasid, lk_addr, lk_sid, lk_pasid, lk_did,
      fill_valid, fill_addr, fill_entry, fill_sl_rd, fill_sl_wr, fill_sl_ex, leaf_valid,
      leaf_entry, leaf_is_pte, chk_valid, chk_global, chk_entry_sid, chk_entry_pasid,
      chk_req_sid, chk_req_has_pasid, chk_req_pasid, ack_dly} <= '0;
    lk_mode <= MAP_FIRST;
    fill_mode <= MAP_FIRST;
    rst_b <= 1'b0;
    five_level <= 1'b1;
    s_axi_wstrb <= 4'hF;
    fill_sid <= SID;
    fill_has_pasid <= 1'b1;
    fill_pasid <= 20'h00033;
    fill_did <= 16'h0044;
    pa = 40'({$urandom, $urandom});
    fill_sl_pa <= ~pa;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    axi_r(REG_CTRL, {RESP_OKAY, CTRL_RESET});
    axi_r(8'h3C, {RESP_SLVERR, 32'h0000_0000});
    axi_w(8'h3C, 32'h0000_0001, RESP_SLVERR);
    axi_w(REG_CTRL, 32'h0000_3811, RESP_OKAY);
    axi_r(REG_CTRL, {RESP_OKAY, 32'h0000_3811});
    // Accessed flag clear and extended flag enabled: both set on write-back
    q_u.push_back({12'h000, pa, 12'h437});
    fill(MAP_FIRST, 64'h00A5_0000_0000_0000, {12'h000, pa, 12'h017}, 3'h7, 1'b1);
    look(MAP_FIRST, 64'h00A5_1234_5678_9000, SID, {1'b1, pa, 7'h68}, 48'hFFFF_FFFF_FFFC);
    look(MAP_FIRST, 64'h01A5_1234_5678_9000, SID, 48'h0, 48'hFFFF_FFFF_FFFF);
    look(MAP_FIRST, 64'h00A5_0000_0000_0000, SID ^ 16'h0001, 48'h0, 48'hFFFF_FFFF_FFFF);
    five_level <= 1'b0;
    look(MAP_FIRST, 64'h00A5_0000_0000_0000, SID, 48'h0, 48'hFFFF_FFFF_FFFF);
    five_level <= 1'b1;
    axi_r(REG_HITS, {RESP_OKAY, 32'h0000_0001});
    fill(MAP_FIRST, 64'h0077_0000_0000_0000, {12'h000, pa, 12'h016}, 3'h7, 1'b0);
    fill(MAP_FIRST, 64'h0077_0000_0000_0000, {12'h000, pa, 12'h4B7}, 3'h7, 1'b0);
    axi_w(REG_CTRL, 32'h0000_3813, RESP_OKAY);
    fill(MAP_FIRST, 64'h0077_0000_0000_0000, {12'h000, pa, 12'h4B7}, 3'h7, 1'b1);
    axi_w(REG_CTRL, 32'h0000_3819, RESP_OKAY);
    fill(MAP_SECOND, 64'h0133_0000_0000_0000, {12'h000, pa, 12'h000}, 3'h7, 1'b0);
    fill(MAP_SECOND, 64'h0133_0000_0000_0000, {12'h000, pa, 12'h001}, 3'h7, 1'b1);
    look(MAP_SECOND, 64'h0133_0000_0ABC_0000, SID, {1'b1, pa, 7'h02}, 48'hFFFF_FFFF_FFC2);
    fill(MAP_NESTED, 64'h0066_0000_0000_0000, {12'h000, pa, 12'h437}, 3'h3, 1'b0);
    fill(MAP_NESTED, 64'h0066_0000_0000_0000, {12'h000, pa, 12'h437}, 3'h4, 1'b1);
    look(MAP_NESTED, 64'h0066_0000_0000_0000, SID, {1'b1, ~pa, 7'h30}, 48'hFFFF_FFFF_FFF0);
    axi_w(REG_CTRL, 32'h0000_3818, RESP_OKAY);
    look(MAP_NESTED, 64'h0066_0000_0000_0000, SID, 48'h0, 48'hFFFF_FFFF_FFFF);
    axi_w(REG_CTRL, 32'h0000_3819, RESP_OKAY);
    axi_w(REG_FLUSH, 32'h0000_0001, RESP_OKAY);
    look(MAP_FIRST, 64'h00A5_0000_0000_0000, SID, 48'h0, 48'hFFFF_FFFF_FFFF);
    axi_r(REG_MISSES, {RESP_OKAY, 32'h0000_0005});
    axi_r(REG_FILLS, {RESP_OKAY, 32'h0000_0004});
    axi_r(REG_STATUS, {RESP_OKAY, 32'h0000_0001});
    // Leaf tagging, every combination of size flag, global flag and level
    for (int i = 0; i < 8; i++)
    begin
      leaf_entry <= {55'h0, i[2], i[1], 7'h00};
      leaf_is_pte <= i[0];
      leaf_valid <= 1'b1;
      q_leaf.push_back(i[2] & (i[0] | i[1]));
      @(posedge clock);
    end
    leaf_valid <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      chk_global <= i[0];
      chk_entry_sid <= SID;
      chk_req_sid <= i[1] ? SID : SID ^ 16'h0100;
      chk_req_has_pasid <= i[2];
      chk_entry_pasid <= 20'h00005;
      chk_req_pasid <= i[3] ? 20'h00005 : 20'h00006;
      chk_valid <= 1'b1;
      q_chk.push_back(i[1] & (i[0] | !i[2] | i[3]));
      @(posedge clock);
    end
    chk_valid <= 1'b0;
    repeat (3) @(posedge clock);
    final_report();
  end
endmodule : tb_top_level_walk_cache
